// ### dmc_host.sv
/*
  Host model: SPI master that frames 32-bit transfers for the register
  block. Assumes the bench clock is 200 MHz; SCLK period is 25 cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module dmc_host (
  input wire logic i_clk,
  input wire logic i_sdo,
  output logic o_csb_n,
  output logic o_sclk,
  output logic o_sdi
);
  initial begin
    o_csb_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi = 1'b0;
  end

  // ****************************************************************
  // One frame: address, read bit, 24 data bits, MSB first
  // ****************************************************************
  task automatic xfer(input logic [6:0] a, input logic rd,
                      input logic [23:0] d, output logic [23:0] q);
    logic [31:0] f;
    f = {a, rd, d};
    q = '0;
    @(negedge i_clk);
    o_csb_n = 1'b0;
    repeat (4) @(negedge i_clk);
    for (int i = 31; i >= 0; i--) begin
      o_sdi = f[i];
      repeat (13) @(negedge i_clk);
      if (i < 24) q = {q[22:0], i_sdo};
      o_sclk = 1'b1;
      repeat (12) @(negedge i_clk);
      o_sclk = 1'b0;
    end
    repeat (4) @(negedge i_clk);
    o_csb_n = 1'b1;
    // Released line shows no stale level
    o_sdi = ~o_sdi;
    repeat (8) @(negedge i_clk);
  endtask : xfer
endmodule : dmc_host

`default_nettype wire

// ### dmc_pkg.sv
/*
  Constants, field layouts and types for the dynamic-mode and command
  register block. Assumes a 200 MHz system clock.
*/
`default_nettype none

package dmc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned ENGAGE_MS = 125;
  localparam int unsigned HOLD_MS = 500;
  localparam int unsigned ENGAGE_CYC = (CLK_HZ / 1000) * ENGAGE_MS;
  localparam int unsigned HOLD_CYC = (CLK_HZ / 1000) * HOLD_MS;
  localparam int CNT_W = 27;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [6:0] ADR_DYN = 7'h05;
  localparam logic [6:0] ADR_SWRST = 7'h08;
  localparam logic [6:0] ADR_RESYNC = 7'h09;
  localparam logic [6:0] ADR_RCLR = 7'h0A;
  localparam logic [6:0] ADR_ID = 7'h0F;

  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam int MODE_LSB = 22;
  localparam int TH_LSB = 16;
  localparam int TH_SCALE_SH = 11;
  localparam int SAMPLE_W = 18;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_MANUAL = 2'h1;
  localparam logic [1:0] MODE_AUTO = 2'h2;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [5:0] TH_RST = 6'h3F;
  localparam logic [3:0] ID_PATTERN = 4'h5;
  localparam logic [5:0] ADDR_BITS = 6'h08;
  localparam logic [5:0] FRAME_BITS = 6'h20;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic csb_n;
    logic sclk;
    logic sdi;
    logic mtb;
  } dmc_pins_t;

  typedef struct packed {
    logic [6:0] addr;
    logic rd;
    logic [23:0] data;
  } dmc_frame_t;

  typedef enum logic [1:0] {
    SPI_IDLE = 2'b01,
    SPI_XFER = 2'b10
  } dmc_spi_st_t;

  typedef enum logic [2:0] {
    REC_OFF = 3'b001,
    REC_WATCH = 3'b010,
    REC_HOLD = 3'b100
  } dmc_rec_st_t;

endpackage : dmc_pkg

`default_nettype wire

// ### dmc_regs.sv
/*
  Dynamic-mode register, command registers and identification word
  behind a 32-bit SPI frame (7-bit address, read bit, 24 data bits).
  Assumes SCLK, CSB, SDI and the master timebase come from outside the
  clock domain and are much slower than i_clk; i_sample is synchronous.
*/
// Function
// - Mode 00 normal, 01 manual recovery held, 10 automatic, 11 reserved
// - Auto: output beyond 2048*threshold over 125ms engages 500ms recovery
// - Threshold field resets to 0x3F
// - Dynamic-mode writes act at once, no resync needed
// - Zero-payload write to 0x08 resets everything on 32nd SCLK edge
// - Software reset equals a power cycle
// - Zero-payload resync acts on next master-timebase edge after frame
// - Resync restarts interval logic and filters, new time origin
// - Resync leaves every configuration register unchanged
// - Zero-payload write to 0x0A clears interval memories
// - Interval-record clear leaves data path and recovery alone
// - Identification word bits 23:20 read alternating pattern
// - Identification holds revision, part nibble and serial field
// - Identification read first after reset returns invalid data
`timescale 1ns/1ps
`default_nettype none

module dmc_regs #(
  parameter int unsigned ENGAGE_CYC = dmc_pkg::ENGAGE_CYC,
  parameter int unsigned HOLD_CYC = dmc_pkg::HOLD_CYC,
  parameter logic [3:0] REVISION = 4'h1,   // Arbitrary value
  parameter logic [3:0] PART_IDENTIFICATION_WORD = 4'h4,  // Arbitrary value
  parameter logic [11:0] SERIAL = 12'h345  // Arbitrary value
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_csb_n,
  input wire logic i_sclk,
  input wire logic i_sdi,
  input wire logic i_master_timebase,
  input wire logic signed [dmc_pkg::SAMPLE_W-1:0] i_sample,
  input wire logic i_sample_valid,
  output logic o_sdo,
  output logic o_sdo_oe_n,
  output logic o_fast_recovery,
  output logic o_resync,
  output logic o_record_clear,
  output logic o_soft_reset,
  output logic [1:0] o_mode,
  output logic [5:0] o_overload_threshold
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  dmc_pkg::dmc_pins_t meta_r, pin_r, prev_r;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_r <= '{csb_n: 1'b1, sclk: 1'b0, sdi: 1'b0, mtb: 1'b0};
      pin_r <= '{csb_n: 1'b1, sclk: 1'b0, sdi: 1'b0, mtb: 1'b0};
      prev_r <= '{csb_n: 1'b1, sclk: 1'b0, sdi: 1'b0, mtb: 1'b0};
    end else begin
      meta_r <= '{csb_n: i_csb_n, sclk: i_sclk, sdi: i_sdi,
                  mtb: i_master_timebase};
      pin_r <= meta_r;
      prev_r <= pin_r;
    end
  end

  logic sclk_rise, sclk_fall, mtb_rise;
  assign sclk_rise = pin_r.sclk & ~prev_r.sclk;
  assign sclk_fall = ~pin_r.sclk & prev_r.sclk;
  assign mtb_rise = pin_r.mtb & ~prev_r.mtb;

  // ****************************************************************
  // Shared state
  // ****************************************************************
  logic [1:0] mode_r, mode_nxt;
  logic [5:0] th_r, th_nxt;
  logic first_r, first_nxt;
  logic done, ld;
  dmc_pkg::dmc_frame_t frame;

  // ****************************************************************
  // SPI frame engine
  // ****************************************************************
  dmc_pkg::dmc_spi_st_t spi_st_r, spi_st_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic [31:0] rx_r, rx_nxt;
  logic [23:0] tx_r, tx_nxt;
  logic rd_r, rd_nxt;
  logic [6:0] adr_r, adr_nxt;
  logic sdo_r, sdo_nxt;
  logic oe_n_r, oe_n_nxt;

  always_comb begin
    spi_st_nxt = spi_st_r;
    cnt_nxt = cnt_r;
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    rd_nxt = rd_r;
    adr_nxt = adr_r;
    sdo_nxt = sdo_r;
    oe_n_nxt = oe_n_r;
    done = 1'b0;
    ld = 1'b0;
    frame = dmc_pkg::dmc_frame_t'({rx_r[30:0], pin_r.sdi});
    unique case (spi_st_r)
      dmc_pkg::SPI_IDLE: begin
        oe_n_nxt = 1'b1;
        cnt_nxt = '0;
        if (!pin_r.csb_n) begin
          spi_st_nxt = dmc_pkg::SPI_XFER;
        end
      end
      dmc_pkg::SPI_XFER: begin
        if (pin_r.csb_n) begin
          spi_st_nxt = dmc_pkg::SPI_IDLE;
          oe_n_nxt = 1'b1;
        end else if (sclk_rise && cnt_r < dmc_pkg::FRAME_BITS) begin
          rx_nxt = {rx_r[30:0], pin_r.sdi};
          cnt_nxt = cnt_r + 6'h01;
          if (cnt_r == dmc_pkg::ADDR_BITS - 6'h01) begin
            ld = 1'b1;
            adr_nxt = rx_nxt[7:1];
            rd_nxt = rx_nxt[0];
            tx_nxt = 24'h000000;
            if (!first_r) begin
              if (rx_nxt[7:1] == dmc_pkg::ADR_DYN) begin
                tx_nxt = {mode_r, th_r, 16'h0000};
              end else if (rx_nxt[7:1] == dmc_pkg::ADR_ID) begin
                tx_nxt = {dmc_pkg::ID_PATTERN, REVISION,
                          PART_IDENTIFICATION_WORD, SERIAL};
              end
            end
          end
          if (cnt_r == dmc_pkg::FRAME_BITS - 6'h01) begin
            done = 1'b1;
          end
        end else if (sclk_fall && rd_r && cnt_r >= dmc_pkg::ADDR_BITS
                     && cnt_r < dmc_pkg::FRAME_BITS) begin
          sdo_nxt = tx_r[23];
          tx_nxt = {tx_r[22:0], 1'b0};
          oe_n_nxt = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      spi_st_r <= dmc_pkg::SPI_IDLE;
      cnt_r <= '0;
      rx_r <= '0;
      tx_r <= '0;
      rd_r <= 1'b0;
      adr_r <= '0;
      sdo_r <= 1'b0;
      oe_n_r <= 1'b1;
    end else begin
      spi_st_r <= spi_st_nxt;
      cnt_r <= cnt_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      rd_r <= rd_nxt;
      adr_r <= adr_nxt;
      sdo_r <= sdo_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  // ****************************************************************
  // Command decode and configuration
  // ****************************************************************
  logic wr, zero, soft_clr, resync_x, rclr_x;
  logic pend_r, pend_nxt;
  logic resync_r, resync_nxt;
  logic clr_r, clr_nxt;
  logic srst_r, srst_nxt;

  always_comb begin
    wr = done & ~frame.rd;
    zero = (frame.data == 24'h000000);
    soft_clr = wr && zero && frame.addr == dmc_pkg::ADR_SWRST;
    resync_x = wr && zero && frame.addr == dmc_pkg::ADR_RESYNC;
    rclr_x = wr && zero && frame.addr == dmc_pkg::ADR_RCLR;
    mode_nxt = mode_r;
    th_nxt = th_r;
    first_nxt = ld ? 1'b0 : first_r;
    if (wr && frame.addr == dmc_pkg::ADR_DYN) begin
      mode_nxt = frame.data[dmc_pkg::MODE_LSB +: 2];
      th_nxt = frame.data[dmc_pkg::TH_LSB +: 6];
    end
    pend_nxt = resync_x | (pend_r & ~mtb_rise);
    resync_nxt = pend_r & mtb_rise;
    clr_nxt = rclr_x;
    srst_nxt = soft_clr;
    if (soft_clr) begin
      mode_nxt = dmc_pkg::MODE_RST;
      th_nxt = dmc_pkg::TH_RST;
      first_nxt = 1'b1;
      pend_nxt = 1'b0;
      resync_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_r <= dmc_pkg::MODE_RST;
      th_r <= dmc_pkg::TH_RST;
      first_r <= 1'b1;
      pend_r <= 1'b0;
      resync_r <= 1'b0;
      clr_r <= 1'b0;
      srst_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      th_r <= th_nxt;
      first_r <= first_nxt;
      pend_r <= pend_nxt;
      resync_r <= resync_nxt;
      clr_r <= clr_nxt;
      srst_r <= srst_nxt;
    end
  end

  // ****************************************************************
  // Overload recovery
  // ****************************************************************
  dmc_pkg::dmc_rec_st_t rec_st_r, rec_st_nxt;
  logic [dmc_pkg::CNT_W-1:0] rcnt_r, rcnt_nxt;
  logic sat_r, sat_nxt;
  logic fast_r, fast_nxt;
  logic [18:0] lim;
  logic signed [18:0] smp;
  logic over, is_auto;

  always_comb begin
    lim = {2'b00, th_r, 11'h000};
    smp = {i_sample[dmc_pkg::SAMPLE_W-1], i_sample};
    over = (smp > $signed(lim)) || (smp < -$signed(lim));
    sat_nxt = i_sample_valid ? over : sat_r;
    is_auto = (mode_r == dmc_pkg::MODE_AUTO);
    rec_st_nxt = rec_st_r;
    rcnt_nxt = rcnt_r;
    unique case (rec_st_r)
      dmc_pkg::REC_OFF: begin
        rcnt_nxt = '0;
        if (is_auto && sat_r) begin
          rec_st_nxt = dmc_pkg::REC_WATCH;
        end
      end
      dmc_pkg::REC_WATCH: begin
        if (!is_auto || !sat_r) begin
          rec_st_nxt = dmc_pkg::REC_OFF;
          rcnt_nxt = '0;
        end else if (rcnt_r == dmc_pkg::CNT_W'(ENGAGE_CYC)) begin
          rec_st_nxt = dmc_pkg::REC_HOLD;
          rcnt_nxt = '0;
        end else begin
          rcnt_nxt = rcnt_r + dmc_pkg::CNT_W'(1);
        end
      end
      dmc_pkg::REC_HOLD: begin
        if (!is_auto || rcnt_r == dmc_pkg::CNT_W'(HOLD_CYC - 1)) begin
          rec_st_nxt = dmc_pkg::REC_OFF;
          rcnt_nxt = '0;
        end else begin
          rcnt_nxt = rcnt_r + dmc_pkg::CNT_W'(1);
        end
      end
    endcase
    fast_nxt = (mode_r == dmc_pkg::MODE_MANUAL)
               || (rec_st_nxt == dmc_pkg::REC_HOLD);
    if (soft_clr) begin
      rec_st_nxt = dmc_pkg::REC_OFF;
      rcnt_nxt = '0;
      sat_nxt = 1'b0;
      fast_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rec_st_r <= dmc_pkg::REC_OFF;
      rcnt_r <= '0;
      sat_r <= 1'b0;
      fast_r <= 1'b0;
    end else begin
      rec_st_r <= rec_st_nxt;
      rcnt_r <= rcnt_nxt;
      sat_r <= sat_nxt;
      fast_r <= fast_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_sdo = sdo_r;
  assign o_sdo_oe_n = oe_n_r;
  assign o_fast_recovery = fast_r;
  assign o_resync = resync_r;
  assign o_record_clear = clr_r;
  assign o_soft_reset = srst_r;
  assign o_mode = mode_r;
  assign o_overload_threshold = th_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  a_mode_write_now: assert property (
    (wr && frame.addr == dmc_pkg::ADR_DYN) |=>
      mode_r == $past(frame.data[23:22]) && th_r == $past(frame.data[21:16]))
    else $error("dynamic-mode write not applied next cycle");

  a_manual_holds: assert property (
    (mode_r == dmc_pkg::MODE_MANUAL)[*2] |-> fast_r)
    else $error("manual mode without recovery active");

  a_soft_defaults: assert property (
    soft_clr |=> th_r == 6'h3F && mode_r == 2'h0 && first_r
      && !fast_r && rec_st_r == dmc_pkg::REC_OFF ##1 !o_soft_reset)
    else $error("software reset left state off default");

  a_resync_edge: assert property (
    (pend_r && !mtb_rise) |=> !o_resync)
    else $error("resync fired before master timebase edge");

  a_resync_keeps: assert property (
    (o_resync && !$past(wr)) |-> $stable(mode_r) && $stable(th_r))
    else $error("resync altered configuration");

  a_clear_pulse: assert property (
    rclr_x |=> o_record_clear && $stable(mode_r) && $stable(th_r)
      && !o_soft_reset && !o_resync ##1 !o_record_clear)
    else $error("record clear pulse wrong");

  a_nonzero_ignored: assert property (
    (done && !frame.rd && frame.data != 24'h000000) |=>
      !o_soft_reset && !o_record_clear && $stable(first_r))
    else $error("nonzero command payload took effect");

  a_id_first_bad: assert property (
    (ld && first_r) |=> tx_r == 24'h000000 && !first_r)
    else $error("first read after reset not blanked");

  a_id_pattern: assert property (
    (ld && !first_r && adr_nxt == dmc_pkg::ADR_ID) |=>
      tx_r[23:20] == 4'h5 && tx_r[15:12] == PART_IDENTIFICATION_WORD)
    else $error("identification pattern wrong");

  a_dyn_unused: assert property (
    (ld && adr_nxt == dmc_pkg::ADR_DYN) |=> tx_r[15:0] == 16'h0000)
    else $error("dynamic-mode unused bits not zero");

  a_hold_bound: assert property (
    (rec_st_r == dmc_pkg::REC_HOLD) |->
      rcnt_r < dmc_pkg::CNT_W'(HOLD_CYC) && fast_r)
    else $error("recovery hold overran or not driven");

endmodule : dmc_regs

`default_nettype wire

// ### test_dmc_regs.sv
/*
  Self-checking bench for dmc_regs driven through the host model.
  Assumes short recovery counts set by parameter.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin \
  n_errors++; $display("[FAIL] %s exp %h got %h", nm, exp, got); end end

module test_dmc_regs;
  localparam int ENG = 20;
  localparam int HLD = 50;
  localparam logic [23:0] ID_EXP = 24'h5AC0C3;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic csb_n, sclk, sdi, sdo, sdo_oe_n, fast, rs, rc, sr;
  logic mtb = 1'b0;
  logic smp_v = 1'b1;
  logic signed [dmc_pkg::SAMPLE_W-1:0] smp = '0;
  logic [1:0] mode;
  logic [5:0] thr;
  logic [23:0] q;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int n_rs = 0;
  int n_rc = 0;
  int n_sr = 0;
  int k;

  always #2.5 i_clk = ~i_clk;

  dmc_host host (.i_clk(i_clk), .i_sdo(sdo), .o_csb_n(csb_n),
    .o_sclk(sclk), .o_sdi(sdi));

  dmc_regs #(.ENGAGE_CYC(ENG), .HOLD_CYC(HLD), .REVISION(4'hA),
    .PART_IDENTIFICATION_WORD(4'hC), .SERIAL(12'h0C3)) dut (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_csb_n(csb_n),
    .i_sclk(sclk), .i_sdi(sdi), .i_master_timebase(mtb),
    .i_sample(smp), .i_sample_valid(smp_v), .o_sdo(sdo),
    .o_sdo_oe_n(sdo_oe_n), .o_fast_recovery(fast), .o_resync(rs),
    .o_record_clear(rc), .o_soft_reset(sr), .o_mode(mode),
    .o_overload_threshold(thr));

  // ****************************************************************
  // Pulse counters and hang guard
  // ****************************************************************
  always @(posedge i_clk) begin
    cyc++;
    if (rs === 1'b1) n_rs++;
    if (rc === 1'b1) n_rc++;
    if (sr === 1'b1) n_sr++;
    if (cyc == 60000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    logic [23:0] x;
    host.xfer(a, 1'b0, d, x);
  endtask : wr

  task automatic rd(input logic [6:0] a, output logic [23:0] d);
    host.xfer(a, 1'b1, 24'h000000, d);
  endtask : rd

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (20) @(negedge i_clk);
    i_arst_n = 1'b1;
    repeat (4) @(negedge i_clk);
    `CHK("mode_rst", 2'h0, mode)
    `CHK("thr_rst", 6'h3F, thr)
    `CHK("oe_idle", 1'b1, sdo_oe_n)
    rd(dmc_pkg::ADR_ID, q);
    `CHK("id_first", 24'h000000, q)
    rd(dmc_pkg::ADR_ID, q);
    `CHK("id_word", ID_EXP, q)
    for (int m = 0; m < 4; m++) begin
      wr(dmc_pkg::ADR_DYN, {2'(m), 6'h15, 16'hFFFF});
      `CHK("mode", 2'(m), mode)
      `CHK("manual", (m == 1), fast)
      rd(dmc_pkg::ADR_DYN, q);
      `CHK("dyn_rd", {2'(m), 6'h15, 16'h0000}, q)
    end
    wr(dmc_pkg::ADR_DYN, {2'h2, 6'h01, 16'h0000});
    // Samples without the valid flag must not count as saturation
    smp_v = 1'b0;
    smp = -18'sd2049;
    repeat (40) @(negedge i_clk);
    `CHK("no_valid", 1'b0, fast)
    smp_v = 1'b1;
    smp = 18'sd2048;
    repeat (40) @(negedge i_clk);
    `CHK("at_limit", 1'b0, fast)
    smp = -18'sd2049;
    repeat (ENG - 5) @(negedge i_clk);
    `CHK("early", 1'b0, fast)
    for (k = 0; k < 20 && fast !== 1'b1; k++) @(negedge i_clk);
    `CHK("engage", 1'b1, (k >= 5 && k <= 9))
    smp = '0;
    for (k = 0; k < 200 && fast === 1'b1; k++) @(negedge i_clk);
    `CHK("hold", HLD, k)
    // Configuration finished before any recording starts
    wr(dmc_pkg::ADR_DYN, {2'h1, 6'h15, 16'h0000});
    wr(dmc_pkg::ADR_SWRST, 24'h000001);
    wr(dmc_pkg::ADR_RESYNC, 24'h000100);
    wr(dmc_pkg::ADR_RCLR, 24'h800000);
    `CHK("nz_cmds", 0, n_rs + n_rc + n_sr)
    `CHK("nz_mode", 2'h1, mode)
    // No lock to wait for here; restart after the change
    wr(dmc_pkg::ADR_RESYNC, 24'h000000);
    repeat (20) @(negedge i_clk);
    `CHK("rs_wait", 0, n_rs)
    mtb = 1'b1;
    repeat (10) @(negedge i_clk);
    mtb = 1'b0;
    `CHK("rs_go", 1, n_rs)
    `CHK("rs_mode", 2'h1, mode)
    `CHK("rs_thr", 6'h15, thr)
    wr(dmc_pkg::ADR_RCLR, 24'h000000);
    `CHK("rclr", 1, n_rc)
    `CHK("rclr_fast", 1'b1, fast)
    `CHK("rclr_rs", 1, n_rs)
    wr(dmc_pkg::ADR_SWRST, 24'h000000);
    `CHK("srst", 1, n_sr)
    `CHK("srst_mode", 2'h0, mode)
    `CHK("srst_thr", 6'h3F, thr)
    `CHK("srst_fast", 1'b0, fast)
    rd(dmc_pkg::ADR_ID, q);
    `CHK("id_first2", 24'h000000, q)
    rd(dmc_pkg::ADR_ID, q);
    `CHK("id_word2", ID_EXP, q)
    rd(7'h33, q);
    `CHK("unmapped", 24'h000000, q)
    tally_and_finish();
  end
endmodule : test_dmc_regs

`default_nettype wire
